/* File: dv/pimb_bench.sv */
// pimb_bench: drives pimb_top over wishbone and events, compares with an integer model
// assumes the one-cycle slave answer and the status indices from pimb_pkg
`timescale 1ns/1ps
module pimb_bench;
  import pimb_pkg::*;
  logic        clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, ack, err, irq, seen, e;
  logic [17:0] adr = '0;
  logic [3:0]  sel = 4'h3, lanes = 4'h3;
  logic [31:0] wdat = '0, q, rdat;
  logic [15:0] ev1 = '0, ev2 = '0;
  int          errors = 0, compares = 0, cycles = 0, m[2], s[2], bits[2], pin, r, lm;
  integer      seed = 32'hC3CF6371;
  pimb_top u_pimb_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(q),
    .wb_ack_o(ack), .wb_err_o(err), .grp1_event_i(ev1), .grp2_event_i(ev2), .irq_o(irq));
  pimb_host_model u_pimb_host_model (.clk_i(clk_i), .irq_i(irq), .irq_seen_o(seen));
  always #12.5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      complete_run;
    end
  end
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    compares++;
    if (got !== want) begin
      errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, want);
    end
  endtask
  task automatic bus(input logic w, input logic [15:0] idx, input logic [15:0] d);
    @(posedge clk_i);
    cyc <= 1;
    stb <= 1;
    we <= w;
    sel <= lanes;
    adr <= {idx, 2'b00};
    wdat <= {16'h0, d};
    // ack or err ends this wait, or else the bench timeout
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1 && err !== 1'b1);
    rdat = q;
    e = err;
    cyc <= 0;
    stb <= 0;
  endtask
  // host sees the request two flops late, so three edges always suffice
  task automatic irqchk;
    repeat (3) @(posedge clk_i);
    chk({31'h0, seen}, 32'((((s[0] & ~m[0]) | (s[1] & ~m[1])) != 0) && pin == 0));
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  initial begin
    bits[0] = PIMB_GRP1_BITS;
    bits[1] = PIMB_GRP2_BITS;
    m = bits;
    s = '{0, 0};
    pin = 0;
    repeat (16) @(posedge clk_i);
    rst_i <= 0;
    bus(0, PIMB_IDX_GRP1_MASK, 16'h0); chk(rdat, m[0]);
    bus(0, PIMB_IDX_GRP2_MASK, 16'h0); chk(rdat, m[1]);
    bus(0, PIMB_IDX_REQ_CTRL, 16'h0); chk(rdat, 0);
    bus(1, 16'h4000, 16'hFFFF); chk({31'h0, e}, 1);
    @(posedge clk_i);
    ev1 <= ~PIMB_GRP1_BITS;
    ev2 <= ~PIMB_GRP2_BITS;
    @(posedge clk_i);
    ev1 <= '0;
    ev2 <= '0;
    bus(0, PIMB_IDX_GRP1_STATUS, 16'h0); chk(rdat, 0);
    bus(0, PIMB_IDX_GRP2_STATUS, 16'h0); chk(rdat, 0);
    for (int g = 0; g < 2; g++) begin
      for (int b = 0; b < 16; b++) begin
        if (bits[g][b]) begin
          @(posedge clk_i);
          if (g == 1) ev2 <= 16'(1 << b);
          else ev1 <= 16'(1 << b);
          @(posedge clk_i);
          ev1 <= '0;
          ev2 <= '0;
          s[g] |= 1 << b;
          irqchk;
          bus(0, 16'(PIMB_IDX_GRP1_STATUS + g), 16'h0); chk(rdat, s[g]);
          m[g] &= ~(1 << b);
          bus(1, 16'(PIMB_IDX_GRP1_MASK + g), 16'(m[g])); irqchk;
          bus(1, 16'(PIMB_IDX_GRP1_STATUS + g), 16'h0); irqchk;
          pin = 1;
          bus(1, PIMB_IDX_REQ_CTRL, 16'h1); irqchk;
          bus(0, PIMB_IDX_REQ_STATE, 16'h0); chk(rdat, 1);
          pin = 0;
          bus(1, PIMB_IDX_REQ_CTRL, 16'h0); irqchk;
          s[g] &= ~(1 << b);
          bus(1, 16'(PIMB_IDX_GRP1_STATUS + g), 16'(1 << b)); irqchk;
          r = $random(seed);
          lanes = 4'($random(seed));
          lm = {{8{lanes[1]}}, {8{lanes[0]}}};
          m[g] = (m[g] & ~lm) | (r & lm & bits[g]);
          bus(1, 16'(PIMB_IDX_GRP1_MASK + g), 16'(r));
          lanes = 4'h3;
          bus(0, 16'(PIMB_IDX_GRP1_MASK + g), 16'h0); chk(rdat, m[g]);
          m[g] = bits[g];
          bus(1, 16'(PIMB_IDX_GRP1_MASK + g), 16'hFFFF);
          $display("test group %0d bit %0d done", g + 1, b);
        end
      end
    end
    // a second reset in mid-run must bring the group2 mask back to set and the pin mask back to clear
    bus(1, PIMB_IDX_GRP2_MASK, 16'h0);
    bus(1, PIMB_IDX_REQ_CTRL, 16'h1);
    rst_i <= 1;
    repeat (2) @(posedge clk_i);
    rst_i <= 0;
    bus(0, PIMB_IDX_GRP2_MASK, 16'h0); chk(rdat, bits[1]);
    bus(0, PIMB_IDX_REQ_CTRL, 16'h0); chk(rdat, 0);
    $display("test reset done");
    complete_run;
  end
endmodule

/* File: dv/pimb_checker.sv */
// pimb_checker: bus and request assertions on the pimb_top ports
// assumes one clock domain and a synchronous active-high reset
`timescale 1ns/1ps
module pimb_checker
  import pimb_pkg::*;
(
  input wire logic                            clk_i,
  input wire logic                            rst_i,
  input wire logic                            wb_cyc_i,
  input wire logic                            wb_stb_i,
  input wire logic                            wb_we_i,
  input wire logic [pimb_pkg::PIMB_ADR_W-1:0] wb_adr_i,
  input wire logic [31:0]                     wb_dat_o,
  input wire logic                            wb_ack_o,
  input wire logic                            wb_err_o,
  input wire logic [15:0]                     grp1_event_i,
  input wire logic [15:0]                     grp2_event_i,
  input wire logic                            irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_taken;
    wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  endsequence
  sequence s_read(logic [15:0] idx);
    wb_ack_o && $past(!wb_we_i && wb_adr_i[17:2] == idx);
  endsequence
  // a taken request is answered in the next cycle, once
  AST_ANSWER: assert property (s_taken |=> wb_ack_o ^ wb_err_o)
    else $error("request not answered after one cycle");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  AST_EXCL: assert property (!(wb_ack_o && wb_err_o))
    else $error("ack and err together");
  AST_QUIET_RESET: assert property ($fell(rst_i) |-> !irq_o [*2])
    else $error("request high right after reset");
  AST_GRP1_READ: assert property (s_read(PIMB_IDX_GRP1_MASK) |->
    (wb_dat_o & ~{16'h0, PIMB_GRP1_BITS}) == 0)
    else $error("group1 mask reads undocumented bits");
  AST_GRP2_READ: assert property (s_read(PIMB_IDX_GRP2_MASK) |->
    (wb_dat_o & ~{16'h0, PIMB_GRP2_BITS}) == 0)
    else $error("group2 mask reads undocumented bits");
  AST_IRQ_RISE: assert property ($rose(irq_o) |->
    $past(wb_ack_o && wb_we_i) || $past(|{grp1_event_i, grp2_event_i}, 2))
    else $error("request rose without cause");
  AST_IRQ_FALL: assert property ($fell(irq_o) |->
    $past(wb_ack_o && wb_we_i) || $past(rst_i))
    else $error("request fell without a write");
endmodule
bind pimb_top pimb_checker u_pimb_checker (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .grp1_event_i(grp1_event_i),
  .grp2_event_i(grp2_event_i), .irq_o(irq_o));

/* File: dv/pimb_host_model.sv */
// pimb_host_model: host side sampling the level request
// assumes the request shares the device clock, so one flop suffices
`timescale 1ns/1ps
module pimb_host_model (
  input  wire logic clk_i,
  input  wire logic irq_i,
  output logic      irq_seen_o
);
  always_ff @(posedge clk_i) begin
    irq_seen_o <= irq_i;
  end
endmodule

/* File: rtl/pimb_event_latch.sv */
// pimb_event_latch: one group of sticky event bits with write-one-to-clear
// assumes event pulses and the clear strobe are on clk_i
`timescale 1ns/1ps
module pimb_event_latch #(
  parameter logic [15:0] VALID_BITS = 16'hFFFF
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [15:0] event_i,
  input  wire logic        clear_i,
  input  wire logic [15:0] clear_data_i,
  output logic      [15:0] status_o
);
  import pimb_pkg::*;

  typedef struct packed {
    logic [15:0] status;
  } pimb_latch_state_type;

  pimb_latch_state_type state;
  pimb_latch_state_type next_state;

  always_comb begin
    next_state = state;
    // a set in the same cycle as its clear wins
    for (int i = 0; i < 16; i++) begin
      if (clear_i && clear_data_i[i]) begin
        next_state.status[i] = 1'b0;
      end
      if (event_i[i] && VALID_BITS[i]) begin
        next_state.status[i] = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign status_o = state.status;
endmodule

/* File: rtl/pimb_pkg.sv */
// pimb_pkg: constants for the interrupt mask bank (register map, field layout, reset values)
// assumes a classic wishbone slave with 32-bit data; word indices times four give byte addresses
// Contract
// - mask zero passes event, one blocks it
// - all documented mask bits reset to one
// - group1 bits 15,12,11,8,7-4,3,2,1 as listed
// - group2 bits 5,4,2,1,0 as listed
// - status bit cleared by writing one
// - global output mask suppresses pin, resets zero
package pimb_pkg;

  // ------------------------------------------------------------
  // register indices (byte address is index times four)
  // ------------------------------------------------------------
  localparam logic [15:0] PIMB_IDX_GRP1_MASK   = 16'h4019;
  localparam logic [15:0] PIMB_IDX_GRP2_MASK   = 16'h401A;
  localparam logic [15:0] PIMB_IDX_GRP1_STATUS = 16'h4010;
  localparam logic [15:0] PIMB_IDX_GRP2_STATUS = 16'h4011;
  localparam logic [15:0] PIMB_IDX_REQ_CTRL    = 16'h4017;
  localparam logic [15:0] PIMB_IDX_REQ_STATE   = 16'h4016;

  localparam int PIMB_ADR_W  = 18;
  localparam int PIMB_DATA_W = 32;
  localparam int PIMB_REG_W  = 16;

  // ------------------------------------------------------------
  // field layout
  // ------------------------------------------------------------
  // group1: 15 supply low, 12 on button, 11 watchdog, 8 adc data,
  // 7..4 comparators 4..1, 3 clock periodic, 2 clock alarm, 1 thermal
  localparam logic [15:0] PIMB_GRP1_BITS = 16'h99FE;
  // group2: 5 otp done, 4 otp error, 2 power on reset, 1 sleep/off, 0 on/wake
  localparam logic [15:0] PIMB_GRP2_BITS = 16'h0037;
  localparam int PIMB_BIT_SUPPLY_LOW   = 15;
  localparam int PIMB_BIT_ON_BUTTON    = 12;
  localparam int PIMB_BIT_WATCHDOG     = 11;
  localparam int PIMB_BIT_ADC_DATA     = 8;
  localparam int PIMB_BIT_OTP_DONE     = 5;
  localparam int PIMB_BIT_OTP_ERROR    = 4;
  localparam int PIMB_BIT_PIN_MASK     = 0;

  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [15:0] PIMB_GRP1_MASK_RST = PIMB_GRP1_BITS;
  localparam logic [15:0] PIMB_GRP2_MASK_RST = PIMB_GRP2_BITS;
  localparam logic        PIMB_PIN_MASK_RST  = 1'h0;

  typedef enum logic [1:0] {
    PIMB_BUS_IDLE = 2'b01,
    PIMB_BUS_ACK  = 2'b10
  } pimb_bus_state_type;

endpackage

/* File: rtl/pimb_top.sv */
// pimb_top: interrupt mask bank with wishbone slave and one level request output
// assumes events come from logic on clk_i as one-cycle or level pulses
`timescale 1ns/1ps
module pimb_top (
  input  wire logic                               clk_i,
  input  wire logic                               rst_i,
  input  wire logic                               wb_cyc_i,
  input  wire logic                               wb_stb_i,
  input  wire logic                               wb_we_i,
  input  wire logic [pimb_pkg::PIMB_ADR_W-1:0]    wb_adr_i,
  input  wire logic [3:0]                         wb_sel_i,
  input  wire logic [pimb_pkg::PIMB_DATA_W-1:0]   wb_dat_i,
  output logic      [pimb_pkg::PIMB_DATA_W-1:0]   wb_dat_o,
  output logic                                    wb_ack_o,
  output logic                                    wb_err_o,
  input  wire logic [15:0]                        grp1_event_i,
  input  wire logic [15:0]                        grp2_event_i,
  output logic                                    irq_o
);
  import pimb_pkg::*;

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    pimb_bus_state_type       bus;
    logic [15:0]              grp1_mask;
    logic [15:0]              grp2_mask;
    logic                     pin_mask;
    logic [PIMB_DATA_W-1:0]   rdata;
    logic                     ack;
    logic                     err;
    logic                     irq;
  } pimb_top_state_type;

  pimb_top_state_type state;
  pimb_top_state_type next_state;

  logic [15:0]            grp1_status;
  logic [15:0]            grp2_status;
  logic                   clr1;
  logic                   clr2;
  logic [15:0]            wr_lo;
  logic [15:0]            index;
  logic                   req;
  logic                   hit;
  logic                   pending;
  logic [15:0]            wr_mask;
  logic [1:0]             lane_en;
  logic                   sel_grp1_mask;
  logic                   sel_grp2_mask;
  logic                   sel_grp1_status;
  logic                   sel_grp2_status;
  logic                   sel_req_ctrl;
  logic                   sel_req_state;
  logic                   wr_req;
  logic [15:0]            grp1_contrib;
  logic [15:0]            grp2_contrib;
  logic [15:0]            grp1_mask_wr;
  logic [15:0]            grp2_mask_wr;
  logic                   pin_mask_wr;
  logic [15:0]            rd_word;
  logic                   irq_next;

  // ------------------------------------------------------------
  // sticky event status
  // ------------------------------------------------------------
  pimb_event_latch #(
    .VALID_BITS (PIMB_GRP1_BITS)
  ) u_grp1 (
    .clk_i        (clk_i),
    .rst_i        (rst_i),
    .event_i      (grp1_event_i),
    .clear_i      (clr1),
    .clear_data_i (wr_lo),
    .status_o     (grp1_status)
  );

  pimb_event_latch #(
    .VALID_BITS (PIMB_GRP2_BITS)
  ) u_grp2 (
    .clk_i        (clk_i),
    .rst_i        (rst_i),
    .event_i      (grp2_event_i),
    .clear_i      (clr2),
    .clear_data_i (wr_lo),
    .status_o     (grp2_status)
  );

  // ------------------------------------------------------------
  // bus decode
  // ------------------------------------------------------------
  // only low 16 bits carry data, so only lanes 0 and 1 matter
  assign lane_en = wb_sel_i[1:0];
  assign wr_mask = {{8{lane_en[1]}}, {8{lane_en[0]}}};
  assign wr_lo   = wb_dat_i[15:0] & wr_mask;
  assign index   = wb_adr_i[PIMB_ADR_W-1:2];
  assign req     = wb_cyc_i && wb_stb_i && state.bus == PIMB_BUS_IDLE;
  assign wr_req  = req && wb_we_i;

  // ------------------------------------------------------------
  // register select
  // ------------------------------------------------------------
  // one select per register keeps the write, read and error paths in step
  assign sel_grp1_mask   = index == PIMB_IDX_GRP1_MASK;
  assign sel_grp2_mask   = index == PIMB_IDX_GRP2_MASK;
  assign sel_grp1_status = index == PIMB_IDX_GRP1_STATUS;
  assign sel_grp2_status = index == PIMB_IDX_GRP2_STATUS;
  assign sel_req_ctrl    = index == PIMB_IDX_REQ_CTRL;
  assign sel_req_state   = index == PIMB_IDX_REQ_STATE;
  // an unmapped index answers with err and changes nothing
  assign hit = sel_grp1_mask
            || sel_grp2_mask
            || sel_grp1_status
            || sel_grp2_status
            || sel_req_ctrl
            || sel_req_state;
  assign clr1 = wr_req && sel_grp1_status;
  assign clr2 = wr_req && sel_grp2_status;

  // ------------------------------------------------------------
  // write data
  // ------------------------------------------------------------
  // unselected lanes keep their bits; undocumented bits never set
  assign grp1_mask_wr = (state.grp1_mask & ~wr_mask)
                      | (wr_lo & PIMB_GRP1_BITS);
  assign grp2_mask_wr = (state.grp2_mask & ~wr_mask)
                      | (wr_lo & PIMB_GRP2_BITS);
  // the pin mask lives in lane 0 only
  assign pin_mask_wr  = lane_en[0] ? wb_dat_i[PIMB_BIT_PIN_MASK] : state.pin_mask;

  // ------------------------------------------------------------
  // per-source contribution
  // ------------------------------------------------------------
  // masked sources still latch; only the contribution is gated
  for (genvar b = 0; b < 16; b++) begin : g_source
    assign grp1_contrib[b] = grp1_status[b]
                          && !state.grp1_mask[b]
                          && PIMB_GRP1_BITS[b];
    assign grp2_contrib[b] = grp2_status[b]
                          && !state.grp2_mask[b]
                          && PIMB_GRP2_BITS[b];
  end
  assign pending  = |grp1_contrib || |grp2_contrib;
  // the pin mask overrides every source mask
  assign irq_next = pending && !state.pin_mask;

  // ------------------------------------------------------------
  // read data
  // ------------------------------------------------------------
  // status reads show masked events too, so software can poll them
  assign rd_word = sel_grp1_mask   ? state.grp1_mask
                 : sel_grp2_mask   ? state.grp2_mask
                 : sel_grp1_status ? grp1_status
                 : sel_grp2_status ? grp2_status
                 : sel_req_ctrl    ? {15'h0000, state.pin_mask}
                 : sel_req_state   ? {15'h0000, pending}
                 : 16'h0000;

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    next_state     = state;
    next_state.ack = 1'b0;
    next_state.err = 1'b0;
    case (state.bus)
      PIMB_BUS_IDLE: begin
        if (req) begin
          next_state.bus   = PIMB_BUS_ACK;
          next_state.ack   = hit;
          next_state.err   = !hit;
          next_state.rdata = '0;
          if (wr_req) begin
            case (index)
              PIMB_IDX_GRP1_MASK: begin
                next_state.grp1_mask = grp1_mask_wr;
              end
              PIMB_IDX_GRP2_MASK: begin
                next_state.grp2_mask = grp2_mask_wr;
              end
              PIMB_IDX_REQ_CTRL: begin
                next_state.pin_mask = pin_mask_wr;
              end
              default: begin
                // status clears act in the latches; the rest is read only
                next_state.pin_mask = state.pin_mask;
              end
            endcase
          end else begin
            next_state.rdata[15:0] = rd_word;
          end
        end
      end
      PIMB_BUS_ACK: begin
        // ack stands one cycle, then the slave waits for the next strobe
        next_state.bus = PIMB_BUS_IDLE;
      end
      default: begin
        next_state.bus = PIMB_BUS_IDLE;
      end
    endcase
    next_state.irq = irq_next;
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state.bus       <= PIMB_BUS_IDLE;
      state.grp1_mask <= PIMB_GRP1_MASK_RST;
      state.grp2_mask <= PIMB_GRP2_MASK_RST;
      state.pin_mask  <= PIMB_PIN_MASK_RST;
      state.rdata     <= '0;
      state.ack       <= 1'b0;
      state.err       <= 1'b0;
      state.irq       <= 1'b0;
    end else begin
      state <= next_state;
    end
  end

  assign wb_dat_o = state.rdata;
  assign wb_ack_o = state.ack;
  assign wb_err_o = state.err;
  assign irq_o    = state.irq;
endmodule
